// ---- design/startup_timing_fault_config.sv ----
// Purpose: rise time, start-up timeout and turn-off delay control with command registers
// Assumes: a bus engine delivers decoded command writes, reads and store/restore strobes
// Notes: times are counted on a 1 ms tick derived from clk_sys
// Behaviour
// - exponent fixed zero, one millisecond per step
// - rise mantissa seven bits, reset five ms
// - rise mantissa rounds to fifteen bucket times
// - timeout timer starts at ramp, faults
// - nonzero limit below rise rejected, flagged
// - zero limit disables timer and check
// - limit mantissa seven bits, reset 100
// - restore defaults returns limit to 100
// - limit quantised same buckets, zero unlimited
// - timeout sets other, voltage summary, timeout flags
// - response low three bits read ones
// - default response shuts down, restarts later
// - select zero ignores, one shuts down
// - retry none latches off, all repeats
// - retry other than 000/111 rejected
// - only retry bit five kept stored
// - store defaults saves response select bit and retry bit five
// - turn-off delay waits before fall
// - rise zero acts as one ms
// - turn-off delay sixteen bucket times
`timescale 1ns/1ps
module startup_timing_fault_config
	import startup_timing_pkg::*;
#(
	parameter int TICK_CYCLES = startup_timing_pkg::TICK_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// command access
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	output logic [15:0] cmd_rdata,
	input wire logic store_all,
	input wire logic restore_all,
	// nonvolatile copy of the response field
	output logic [1:0] nv_action,
	input wire logic [1:0] nv_action_in,
	// status interface
	output logic cml_flag,
	output logic invalid_data_flag,
	output logic other_fault_flag,
	output logic output_voltage_summary_flag,
	output logic startup_timeout_flag,
	input wire logic clear_faults,
	output logic smbalert,
	// power stage
	input wire logic start_cmd,
	input wire logic uv_reached,
	input wire logic other_shutdown,
	output logic ramp_active,
	output logic output_enable
);
	import startup_timing_pkg::*;

	initial begin
		if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) $error("tick cycles out of range");
	end

	// quantise a programmed mantissa to the supported millisecond buckets
	function automatic logic [6:0] bucket(input logic [6:0] m);
		if (m <= 7'd6) bucket = m;
		else if (m <= 7'd9) bucket = 7'd7;
		else if (m <= 7'd12) bucket = 7'd10;
		else if (m <= 7'd17) bucket = 7'd14;
		else if (m <= 7'd22) bucket = 7'd19;
		else if (m <= 7'd32) bucket = 7'd27;
		else if (m <= 7'd44) bucket = 7'd37;
		else if (m <= 7'd62) bucket = 7'd52;
		else if (m <= 7'd86) bucket = 7'd72;
		else bucket = 7'd100;
	endfunction : bucket

	// whole state of the block in one record
	typedef struct packed {
		logic [15:0] tick_cnt;   // divider toward the 1 ms tick
		logic [6:0] rise;        // rise-time mantissa
		logic [6:0] limit;       // timeout limit mantissa
		logic [6:0] offdly;      // turn-off delay mantissa
		logic resp_shut;         // respond shutdown select
		logic [2:0] retry;       // retry select
		logic [9:0] ms_cnt;      // elapsed ms in the current interval
		logic [9:0] to_cnt;      // elapsed ms since ramp began
		seq_t st;                // sequencer state
		logic cml;
		logic ivd;
		logic oth;
		logic vsum;
		logic tmo;
		logic ignored;           // timeout already reported while ignoring
		logic [1:0] nv;          // nonvolatile image
	} state_t;

	state_t s_reg, s_next;
	logic tick;
	logic [6:0] rise_eff;
	logic [6:0] limit_eff;
	logic [9:0] restart_ms;
	logic timeout_hit;
	logic [6:0] wm;

	// a tick pulses once every TICK_CYCLES edges
	assign tick = (s_reg.tick_cnt == 16'(TICK_CYCLES - 1));
	assign rise_eff = (s_reg.rise == 7'h00) ? 7'd1 : bucket(s_reg.rise);
	assign limit_eff = bucket(s_reg.limit);
	assign restart_ms = 10'(RESTART_PERIODS) * 10'(rise_eff);
	assign wm = cmd_wdata[6:0];
	// zero limit leaves the timer idle forever
	assign timeout_hit = (s_reg.st == ST_RAMP) && !uv_reached && (limit_eff != 7'h00)
		&& (s_reg.to_cnt >= 10'(limit_eff));

	// next-state logic
	always_comb begin
		s_next = s_reg;
		s_next.tick_cnt = tick ? 16'h0000 : s_reg.tick_cnt + 16'h0001;
		// clears are applied first so that a set in the same cycle wins
		// and a fault that lands on the clear strobe is never lost
		if (clear_faults) begin
			s_next.cml = 1'b0;
			s_next.ivd = 1'b0;
			s_next.oth = 1'b0;
			s_next.vsum = 1'b0;
			s_next.tmo = 1'b0;
		end
		// writes; upper mantissa and exponent bits are never stored
		if (cmd_wr) begin
			unique case (cmd_code)
				CMD_RISE_TIME: begin
					s_next.rise = wm;
				end
				CMD_TIMEOUT_LIMIT: begin
					// nonzero limit shorter than rise time is refused
					if (wm != 7'h00 && bucket(wm) < rise_eff) begin
						s_next.cml = 1'b1;
						s_next.ivd = 1'b1;
					end else begin
						s_next.limit = wm;
					end
				end
				CMD_TIMEOUT_ACTION: begin
					if (cmd_wdata[5:3] != RETRY_NONE && cmd_wdata[5:3] != RETRY_ALWAYS) begin
						s_next.cml = 1'b1;
						s_next.ivd = 1'b1;
					end else begin
						s_next.resp_shut = cmd_wdata[ACT_SHUT_BIT];
						s_next.retry = cmd_wdata[5:3];
					end
				end
				CMD_TURN_OFF_DELAY: begin
					s_next.offdly = wm;
				end
				default: begin
				end
			endcase
		end
		if (store_all) begin
			s_next.nv = {s_reg.resp_shut, s_reg.retry[2]};
		end
		if (restore_all) begin
			s_next.limit = LIMIT_RST;
			s_next.resp_shut = s_reg.nv[1];
			s_next.retry = {3{s_reg.nv[0]}};
		end
		// sequencer; timer and flag sets come after clears so they win
		if (tick) begin
			s_next.ms_cnt = s_reg.ms_cnt + 10'h001;
			s_next.to_cnt = s_reg.to_cnt + 10'h001;
		end
		unique case (s_reg.st)
			ST_OFF: begin
				s_next.ms_cnt = 10'h000;
				s_next.to_cnt = 10'h000;
				s_next.ignored = 1'b0;
				if (start_cmd) s_next.st = ST_RAMP;
			end
			ST_RAMP: begin
				if (s_reg.ms_cnt >= 10'(rise_eff) && uv_reached) s_next.st = ST_ON;
				if (timeout_hit && !s_reg.ignored) begin
					s_next.oth = 1'b1;
					s_next.vsum = 1'b1;
					s_next.tmo = 1'b1;
					s_next.ignored = 1'b1;
					s_next.ms_cnt = 10'h000;
					if (s_reg.resp_shut) begin
						// shutdown path follows the retry setting
						s_next.st = (s_reg.retry == RETRY_NONE) ? ST_LATCHED : ST_RESTART;
					end
				end
			end
			ST_ON: begin
				s_next.ms_cnt = 10'h000;
				if (!start_cmd) s_next.st = ST_OFF_WAIT;
			end
			ST_OFF_WAIT: begin
				// output stays up for the quantised turn-off delay
				if (s_reg.ms_cnt >= 10'(bucket(s_reg.offdly))) s_next.st = ST_OFF;
			end
			ST_RESTART: begin
				s_next.to_cnt = 10'h000;
				if (s_reg.ms_cnt >= restart_ms) begin
					s_next.st = ST_RAMP;
					s_next.ms_cnt = 10'h000;
					s_next.ignored = 1'b0;
				end
			end
			ST_LATCHED: begin
				if (clear_faults) s_next.st = ST_OFF;
			end
		endcase
		// a command off or another fault ends any retry loop
		if ((!start_cmd && s_reg.st != ST_ON && s_reg.st != ST_OFF_WAIT) || other_shutdown) begin
			s_next.st = ST_OFF;
		end
	end

	// state register with synchronous reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_reg <= '{tick_cnt: 16'h0000, rise: RISE_RST, limit: LIMIT_RST, offdly: OFFDLY_RST,
				resp_shut: RESP_SHUT_RST, retry: RETRY_RST, ms_cnt: 10'h000, to_cnt: 10'h000,
				st: ST_OFF, cml: 1'b0, ivd: 1'b0, oth: 1'b0, vsum: 1'b0, tmo: 1'b0,
				ignored: 1'b0, nv: 2'h3};
		end else begin
			s_reg <= s_next;
		end
	end

	// read mux; exponent and upper mantissa bits read zero
	always_comb begin
		unique case (cmd_code)
			CMD_RISE_TIME: cmd_rdata = {9'h000, s_reg.rise};
			CMD_TIMEOUT_LIMIT: cmd_rdata = {9'h000, s_reg.limit};
			CMD_TIMEOUT_ACTION: cmd_rdata = {8'h00, s_reg.resp_shut, 1'b0, s_reg.retry,
				RESTART_FIELD};
			CMD_TURN_OFF_DELAY: cmd_rdata = {9'h000, s_reg.offdly};
			default: cmd_rdata = 16'h0000;
		endcase
	end

	// outputs
	assign nv_action = s_reg.nv;
	assign cml_flag = s_reg.cml;
	assign invalid_data_flag = s_reg.ivd;
	assign other_fault_flag = s_reg.oth;
	assign output_voltage_summary_flag = s_reg.vsum;
	assign startup_timeout_flag = s_reg.tmo;
	assign smbalert = s_reg.cml | s_reg.tmo;
	assign ramp_active = (s_reg.st == ST_RAMP);
	assign output_enable = (s_reg.st == ST_RAMP) || (s_reg.st == ST_ON) || (s_reg.st == ST_OFF_WAIT);

	// assertions
	sequence seq_bad_limit;
		cmd_wr && cmd_code == CMD_TIMEOUT_LIMIT && wm != 7'h00 && bucket(wm) < rise_eff;
	endsequence
	AST_LIMIT_REJECT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		seq_bad_limit and !clear_faults |=> cml_flag && invalid_data_flag && smbalert
		&& s_reg.limit == $past(s_reg.limit)) else $error("bad limit accepted");
	AST_ZERO_LIMIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && cmd_code == CMD_TIMEOUT_LIMIT && wm == 7'h00 |=> s_reg.limit == 7'h00)
		else $error("zero limit refused");
	AST_RETRY_REJECT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && cmd_code == CMD_TIMEOUT_ACTION && cmd_wdata[5:3] == 3'h2
		|=> $stable(s_reg.retry) && invalid_data_flag) else $error("bad retry accepted");
	AST_LOW_BITS: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmd_code == CMD_TIMEOUT_ACTION |-> cmd_rdata[2:0] == 3'h7 && cmd_rdata[6] == 1'b0)
		else $error("response low bits wrong");
	AST_EXP_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmd_code == CMD_RISE_TIME |-> cmd_rdata[15:7] == 9'h000) else $error("exponent nonzero");
	AST_TIMEOUT_FLAGS: assert property (@(posedge clk_sys) disable iff (sys_rst)
		timeout_hit && !s_reg.ignored |=> other_fault_flag && output_voltage_summary_flag
		&& startup_timeout_flag && smbalert) else $error("timeout flags missing");
	AST_IGNORE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		timeout_hit && !s_reg.resp_shut && start_cmd && !other_shutdown |=> ramp_active)
		else $error("ignore mode stopped");
	AST_LATCH: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_reg.st == ST_LATCHED && !clear_faults |=> !output_enable) else $error("latched on");
	AST_RESTORE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		restore_all |=> s_reg.limit == LIMIT_RST) else $error("restore missed limit");
	AST_RISE_MIN: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_reg.rise == 7'h00 |-> rise_eff == 7'd1) else $error("zero rise not 1 ms");

	// further checks on the command side and the sequencer
	// a rejected limit met by a clear in the same cycle still leaves its flags
	sequence seq_clear_now;
		clear_faults;
	endsequence

	// the set must win over a clear that arrives together with it
	AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (sys_rst)
		seq_bad_limit and seq_clear_now |=> cml_flag && invalid_data_flag)
		else $error("clear beat a rejected write");

	// a rise write stores the low seven bits and nothing else
	AST_RISE_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && cmd_code == CMD_RISE_TIME |=> s_reg.rise == $past(wm))
		else $error("rise write lost");

	// a legal action write takes the select bit and the retry field
	AST_ACTION_TAKE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmd_wr && cmd_code == CMD_TIMEOUT_ACTION && !restore_all
		&& (cmd_wdata[5:3] == RETRY_NONE || cmd_wdata[5:3] == RETRY_ALWAYS)
		|=> s_reg.resp_shut == $past(cmd_wdata[ACT_SHUT_BIT])
		&& s_reg.retry == $past(cmd_wdata[5:3])) else $error("action write lost");

	// store keeps only the select bit and one retry bit
	AST_STORE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		store_all |=> nv_action == $past({s_reg.resp_shut, s_reg.retry[2]}))
		else $error("store missed action");

	// a start command from the off state begins the ramp at once
	AST_RAMP_START: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_reg.st == ST_OFF && start_cmd && !other_shutdown |=> ramp_active)
		else $error("ramp did not start");

	// with no limit the timeout flag can never be raised by the ramp
	AST_ZERO_LIMIT_RUN: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_reg.limit == 7'h00 && ramp_active && !startup_timeout_flag
		|=> !startup_timeout_flag) else $error("timeout with no limit");

	// the output stays off for the whole restart wait
	AST_RESTART_OFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_reg.st == ST_RESTART |-> !output_enable && !ramp_active)
		else $error("output up during restart wait");

	// the output stays up when the stop arrives, for the turn-off delay
	AST_OFF_DELAY: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_reg.st == ST_ON && !start_cmd && !other_shutdown |=> output_enable)
		else $error("output fell without delay");

	// another fault ends any state, retry loops included
	AST_OTHER_OFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
		other_shutdown |=> !output_enable) else $error("other fault ignored");
endmodule : startup_timing_fault_config

// ---- design/startup_timing_pkg.sv ----
// Purpose: shared constants for the start-up timing and fault configuration block
// Assumes: 10 MHz system clock, command codes presented by an upstream bus engine
// Notes: all times are in milliseconds, linear format with exponent fixed at zero
package startup_timing_pkg;
	// command codes
	localparam logic [7:0] CMD_RISE_TIME = 8'h61;
	localparam logic [7:0] CMD_TIMEOUT_LIMIT = 8'h62;
	localparam logic [7:0] CMD_TIMEOUT_ACTION = 8'h63;
	localparam logic [7:0] CMD_TURN_OFF_DELAY = 8'h64;
	// field layout
	localparam int MANT_W = 7;
	localparam int ACT_SHUT_BIT = 7;
	localparam int ACT_RETRY_LSB = 3;
	localparam int ACT_NV_BIT = 5;
	// reset values and fixed field codes
	localparam logic [6:0] RISE_RST = 7'h05;
	localparam logic [6:0] LIMIT_RST = 7'h64;
	localparam logic [6:0] OFFDLY_RST = 7'h00;
	localparam logic RESP_SHUT_RST = 1'h1;
	localparam logic [2:0] RETRY_RST = 3'h7;
	localparam logic [2:0] RESTART_FIELD = 3'h7;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_ALWAYS = 3'h7;
	localparam logic [7:0] RESTART_PERIODS = 8'h07;
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
	// controller states
	typedef enum logic [2:0] {ST_OFF, ST_RAMP, ST_ON, ST_OFF_WAIT, ST_RESTART, ST_LATCHED} seq_t;
endpackage : startup_timing_pkg

// ---- verification/host_model.sv ----
// Purpose: host side model issuing command writes, reads and strobes
// Assumes: the block samples its inputs at the rising edge of clk_sys
// Notes: released write data shows the inverse of its last value
`timescale 1ns/1ps
module host_model (
	// clock
	input wire logic clk_sys,
	// command bus
	output logic cmd_wr,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	input wire logic [15:0] cmd_rdata,
	// strobes
	output logic store_all,
	output logic restore_all,
	output logic clear_faults
);
	initial begin
		{cmd_wr, store_all, restore_all, clear_faults} = 4'h0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// one-cycle write; the data is scrambled once released
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk_sys);
		cmd_code = c;
		cmd_wdata = d;
		cmd_wr = 1'b1;
		@(negedge clk_sys);
		cmd_wr = 1'b0;
		cmd_wdata = ~d;
	endtask : wr
	// read data follows the code without a clock
	task automatic rd(input logic [7:0] c, output logic [15:0] q);
		@(negedge clk_sys);
		cmd_code = c;
		#1 q = cmd_rdata;
	endtask : rd
	// one-cycle pulse: 0 store, 1 restore, 2 clear
	task automatic pulse(input int k);
		@(negedge clk_sys);
		{clear_faults, restore_all, store_all} = 3'h1 << k;
		@(negedge clk_sys);
		{clear_faults, restore_all, store_all} = 3'h0;
	endtask : pulse
endmodule : host_model

// ---- verification/tb.sv ----
// Purpose: self-checking bench for the start-up timing block
// Assumes: host_model drives the command side at the falling edge
// Notes: tick cut to 10 cycles, so one ms lasts 1 us here
`timescale 1ns/1ps
module tb;
	import startup_timing_pkg::*;
	localparam int TK = 10; // shortened tick keeps the run brief
	logic clk_sys, sys_rst, start_cmd, uv_reached, cmd_wr, store_all, restore_all, clear_faults;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, cmd_rdata, v;
	logic [1:0] nv_action, nv_action_in;
	logic other_shutdown;
	logic cml_flag, invalid_data_flag, other_fault_flag, output_voltage_summary_flag;
	logic startup_timeout_flag, smbalert, ramp_active, output_enable;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	// rise, limit, refused
	logic [6:0] rz [7] = '{7'h00, 7'h05, 7'h07, 7'h07, 7'h56, 7'h56, 7'h7f};
	logic [6:0] lz [7] = '{7'h01, 7'h02, 7'h09, 7'h06, 7'h3e, 7'h3f, 7'h00};
	logic rj [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	startup_timing_fault_config #(.TICK_CYCLES(TK)) dut (.*);
	host_model host (.*);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// hang guard, far above the expected run length
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		host.rd(c, v);
		chk(v, e);
	endtask : rd
	// alert flags as {cml, invalid data, alert}
	task automatic fl(input logic [2:0] e);
		@(negedge clk_sys);
		chk({13'h0, cml_flag, invalid_data_flag, smbalert}, {13'h0, e});
	endtask : fl
	// bounded wait for a level, then judge it
	task automatic wt(ref logic s, input logic e, input int n);
		for (int k = 0; k < n && s !== e; k++) begin
			@(negedge clk_sys);
		end
		chk({15'h0, s}, {15'h0, e});
	endtask : wt
	task automatic t_regs();
		rd(CMD_RISE_TIME, 16'h0005);
		rd(CMD_TIMEOUT_LIMIT, 16'h0064);
		rd(CMD_TIMEOUT_ACTION, 16'h00bf);
		rd(CMD_TURN_OFF_DELAY, 16'h0000);
		chk({14'h0, nv_action}, 16'h0003);
		host.wr(CMD_RISE_TIME, 16'hffff);
		rd(CMD_RISE_TIME, 16'h007f);
		host.wr(CMD_TIMEOUT_LIMIT, 16'hffff);
		rd(CMD_TIMEOUT_LIMIT, 16'h007f);
	endtask : t_regs
	// quantised limit against rise, zero always taken
	task automatic t_limit();
		for (int i = 0; i < 7; i++) begin
			host.wr(CMD_TIMEOUT_LIMIT, 16'h0000);
			host.wr(CMD_RISE_TIME, {9'h0, rz[i]});
			host.wr(CMD_TIMEOUT_LIMIT, {9'h0, lz[i]});
			rd(CMD_TIMEOUT_LIMIT, rj[i] ? 16'h0000 : {9'h0, lz[i]});
			fl({3{rj[i]}});
			host.pulse(2);
		end
		host.pulse(1);
		rd(CMD_TIMEOUT_LIMIT, 16'h0064);
	endtask : t_limit
	task automatic t_action();
		host.wr(CMD_TIMEOUT_ACTION, 16'h0090);
		rd(CMD_TIMEOUT_ACTION, 16'h00bf);
		fl(3'h7);
		host.pulse(2);
		host.wr(CMD_TIMEOUT_ACTION, 16'h0000);
		rd(CMD_TIMEOUT_ACTION, 16'h0007);
		host.pulse(0);
		@(negedge clk_sys);
		chk({14'h0, nv_action}, 16'h0000);
		host.wr(CMD_TIMEOUT_ACTION, 16'h00b8);
		host.pulse(1);
		rd(CMD_TIMEOUT_ACTION, 16'h0007);
	endtask : t_action
	// 1 ms rise, 3 ms limit, output never reaches its threshold
	task automatic fault_run(input logic [7:0] act);
		host.wr(CMD_TIMEOUT_ACTION, {8'h00, act});
		host.wr(CMD_RISE_TIME, 16'h0000);
		host.wr(CMD_TIMEOUT_LIMIT, 16'h0003);
		host.pulse(2);
		start_cmd = 1'b1;
		wt(ramp_active, 1'b1, 5);
		repeat (2 * TK - 2) @(negedge clk_sys);
		chk({15'h0, startup_timeout_flag}, 16'h0000);
		wt(startup_timeout_flag, 1'b1, 2 * TK);
		chk({13'h0, other_fault_flag, output_voltage_summary_flag, smbalert}, 16'h0007);
	endtask : fault_run
	task automatic stop_run();
		start_cmd = 1'b0;
		uv_reached = 1'b0;
		repeat (8 * TK) @(negedge clk_sys);
		host.pulse(2);
	endtask : stop_run
	task automatic t_shut();
		fault_run(8'hb8);
		wt(output_enable, 1'b0, 3);
		repeat (5 * TK) @(negedge clk_sys);
		chk({15'h0, ramp_active}, 16'h0000);
		wt(ramp_active, 1'b1, 3 * TK);
		stop_run();
	endtask : t_shut
	task automatic t_ignore();
		fault_run(8'h38);
		repeat (3) @(negedge clk_sys);
		chk({14'h0, output_enable, ramp_active}, 16'h0003);
		stop_run();
	endtask : t_ignore
	task automatic t_latch();
		fault_run(8'h80);
		wt(output_enable, 1'b0, 3);
		repeat (15 * TK) @(negedge clk_sys);
		chk({14'h0, output_enable, ramp_active}, 16'h0000);
		stop_run();
	endtask : t_latch
	// no limit: ramp runs on, then a 5 ms turn-off delay
	task automatic t_nolimit();
		host.wr(CMD_TIMEOUT_LIMIT, 16'h0000);
		host.wr(CMD_TURN_OFF_DELAY, 16'h0005);
		start_cmd = 1'b1;
		repeat (20 * TK) @(negedge clk_sys);
		chk({14'h0, startup_timeout_flag, ramp_active}, 16'h0001);
		uv_reached = 1'b1;
		repeat (3) @(negedge clk_sys);
		start_cmd = 1'b0;
		repeat (3 * TK + 5) @(negedge clk_sys);
		chk({15'h0, output_enable}, 16'h0001);
		wt(output_enable, 1'b0, 3 * TK);
	endtask : t_nolimit
	// another fault forces the output off from a running start
	task automatic t_other();
		start_cmd = 1'b1;
		wt(ramp_active, 1'b1, 5);
		other_shutdown = 1'b1;
		@(negedge clk_sys);
		chk({15'h0, output_enable}, 16'h0000);
		other_shutdown = 1'b0;
		start_cmd = 1'b0;
		@(negedge clk_sys);
	endtask : t_other
	initial begin
		sys_rst = 1'b1;
		start_cmd = 1'b0;
		uv_reached = 1'b0;
		other_shutdown = 1'b0;
		nv_action_in = 2'h3;
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'b0;
		t_regs();
		t_limit();
		t_action();
		t_shut();
		t_ignore();
		t_latch();
		t_nolimit();
		t_other();
		tally_and_finish();
	end
	task automatic tally_and_finish();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
endmodule : tb
